// ### sbm_bit_timer.sv
// Quarter-bit tick and phase generator for the serial clock
`timescale 1ns/100ps
module sbm_bit_timer
    import sbm_pkg::*;
(
    input  wire logic link_clk,
    input  wire logic rst,
    sbm_timer_if.tmr  t
);
    logic [8:0] cnt;

    assign t.tick = t.run && (cnt == SBM_QTR_LAST);

    // Restarts at phase 0 so every frame begins aligned
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cnt     <= 9'h000;
            t.phase <= 2'h0;
        end else if (!t.run) begin
            cnt     <= 9'h000;
            t.phase <= 2'h0;
        end else if (t.tick) begin
            cnt     <= 9'h000;
            t.phase <= t.phase + 2'h1;
        end else begin
            cnt     <= cnt + 9'h001;
        end
    end
endmodule

// ### sbm_eeprom_model.sv
// Behavioural serial EEPROM slave on the two-wire bus
`timescale 1ns/100ps
module sbm_eeprom_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack_addr,
    output logic      sda_pull
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] word;
    logic       addr_ph = 1'b0;
    logic       act = 1'b0;
    logic       rd = 1'b0;
    logic       dat = 1'b0;
    logic       got_word = 1'b0;
    int         b = 0;
    int         starts = 0;
    initial sda_pull = 1'b0;
    always @(negedge sda) if (scl) begin
        b = 0;
        addr_ph = 1'b1;
        got_word = 1'b0;
        starts++;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) begin
        if (b < 8) sh = {sh[6:0], sda};
        else if (dat && act) begin // Master nack ends the read
            word++;
            act = !sda;
        end
        b = (b == 8) ? 0 : b + 1;
    end
    // Only move SDA while SCL is low
    always @(negedge scl) begin
        sda_pull = 1'b0;
        if (b == 8 && addr_ph) begin
            act = sh[7:1] == 7'b1010_000 && !nack_addr;
            rd = sh[0];
            addr_ph = 1'b0;
            dat = 1'b0;
            sda_pull = act;
        end else if (b == 8 && act && !rd) begin
            if (got_word) mem[word++] = sh;
            else word = sh;
            got_word = 1'b1;
            sda_pull = 1'b1;
        end else if (act && rd && b < 8) begin
            dat = 1'b1;
            sda_pull = !mem[word][7 - b]; // MSB first
        end
    end
endmodule

// ### sbm_pkg.sv
// Constants and types shared by the serial EEPROM bus master
package sbm_pkg;

    // Register offsets in configuration space
    localparam logic [7:0] SBM_OFS_DATA  = 8'hb0;
    localparam logic [7:0] SBM_OFS_WORD  = 8'hb1;
    localparam logic [7:0] SBM_OFS_CTRL  = 8'hb3;

    // Control/status field positions
    localparam int SBM_BIT_RD_REQ  = 0;
    localparam int SBM_BIT_WR_REQ  = 1;
    localparam int SBM_BIT_ERR     = 2;
    localparam int SBM_BIT_PRESENT = 3;
    localparam int SBM_BIT_BUSY    = 4;
    localparam int SBM_BIT_LOADING = 5;
    localparam int SBM_BIT_SKIP    = 7;

    // Values after reset
    localparam logic [7:0] SBM_RST_BYTE = 8'h00;

    // Fixed slave address, read and write forms
    localparam logic [6:0] SBM_DEV_ADDR = 7'h50;
    localparam logic [7:0] SBM_DEV_WR   = {SBM_DEV_ADDR, 1'b0};
    localparam logic [7:0] SBM_DEV_RD   = {SBM_DEV_ADDR, 1'b1};

    // Automatic load layout
    localparam logic [6:0] SBM_LOAD_BYTES  = 7'h52;
    localparam logic [6:0] SBM_UP_BYTES    = 7'h28;
    localparam logic [6:0] SBM_GROUP_BYTES = 7'h0e;
    localparam logic [7:0] SBM_LOAD_START  = 8'h00;

    // Serial clock timing on the link clock
    localparam int SBM_SCL_FREQ_HZ       = 60000;
    localparam int SBM_LINK_CLK_NS       = 15;
    localparam int SBM_QTR_CYC           =
        1000000000 / (SBM_SCL_FREQ_HZ * 4 * SBM_LINK_CLK_NS);
    localparam logic [8:0] SBM_QTR_LAST  = 9'(SBM_QTR_CYC - 1);
    localparam logic [3:0] SBM_ACK_BIT   = 4'h8;

    typedef enum logic [4:0] {
        E_IDLE  = 5'h01,
        E_START = 5'h02,
        E_TX    = 5'h04,
        E_RX    = 5'h08,
        E_STOP  = 5'h10
    } sbm_eng_e;

    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ  = 2'h1,
        OP_MREAD = 2'h2
    } sbm_op_e;

    typedef enum logic [1:0] {
        STEP_DEV_W = 2'h0,
        STEP_WORD  = 2'h1,
        STEP_DATA  = 2'h2,
        STEP_DEV_R = 2'h3
    } sbm_step_e;

endpackage

// ### sbm_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module sbm_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### sbm_timer_if.sv
// Bit timing handshake between the engine and the quarter-bit timer
`timescale 1ns/100ps
interface sbm_timer_if;
    logic       run;
    logic       tick;
    logic [1:0] phase;

    modport eng (output run, input tick, input phase);
    modport tmr (input run, output tick, output phase);
endinterface

// ### sbm_top.sv
// Two-wire EEPROM bus master: detect, auto load and software byte access
`timescale 1ns/100ps
module sbm_top
    import sbm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       link_clk,
    input  wire logic       rst,
    input  wire logic       pcie_reset_n,
    input  wire logic       global_reset_n,
    input  wire logic [7:0] cfg_addr,
    input  wire logic       cfg_wr,
    input  wire logic       cfg_rd,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            load_valid,
    output logic      [1:0] load_port,
    output logic      [6:0] load_offset,
    output logic      [7:0] load_data
);
    // Reference clock side
    logic       pcie_s, global_reset_n_s, scl_s, done_s, byte_s;
    logic       released, rel_q, rise;
    logic       strap_ok, bus_present_flag, bus_error_flag;
    logic       word_address_skip_select;
    logic [7:0] data_reg, word_reg;
    logic       req_rd, req_wr, busy, load_busy, load_pend;
    logic       cmd_tgl, done_q, byte_q, done_evt, byte_evt;
    logic       launch_sw, launch_ld, ctrl_wr;
    sbm_op_e    c_op;
    logic [7:0] c_word, c_wdata;
    logic [6:0] c_count, load_cnt;
    logic       c_skip;

    // Link clock side
    logic       cmd_s, cmd_q, sda_s;
    sbm_eng_e   e_state;
    sbm_step_e  step;
    sbm_op_e    e_op;
    logic [7:0] shreg, rdata, e_word, e_wdata;
    logic [6:0] e_left;
    logic [3:0] bit_cnt;
    logic       e_skip, e_restart, e_err, ack_smp;
    logic       done_tgl, byte_tgl;
    logic       next_scl, next_sda, e_read;

    sbm_timer_if tif ();

    sbm_bit_timer u_timer (
        .link_clk (link_clk),
        .rst      (rst),
        .t        (tif)
    );

    sbm_sync u_s_pcie (.clk(ref_clk),  .rst(rst), .d(pcie_reset_n),
                       .q(pcie_s));
    sbm_sync u_s_global_reset_n (.clk(ref_clk),  .rst(rst), .d(global_reset_n),
                       .q(global_reset_n_s));
    sbm_sync u_s_scl  (.clk(ref_clk),  .rst(rst), .d(scl_i),    .q(scl_s));
    sbm_sync u_s_done (.clk(ref_clk),  .rst(rst), .d(done_tgl), .q(done_s));
    sbm_sync u_s_byte (.clk(ref_clk),  .rst(rst), .d(byte_tgl), .q(byte_s));
    sbm_sync u_s_cmd  (.clk(link_clk), .rst(rst), .d(cmd_tgl),  .q(cmd_s));
    sbm_sync u_s_sda  (.clk(link_clk), .rst(rst), .d(sda_i),    .q(sda_s));

    // Upstream or downstream port owning a loaded byte
    function automatic logic [1:0] port_of(input logic [6:0] a);
        if (a < SBM_UP_BYTES)
            port_of = 2'h0;
        else if (a < 7'(SBM_UP_BYTES + SBM_GROUP_BYTES))
            port_of = 2'h1;
        else if (a < 7'(SBM_UP_BYTES + 2 * SBM_GROUP_BYTES))
            port_of = 2'h2;
        else
            port_of = 2'h3;
    endfunction

    assign released = pcie_s & global_reset_n_s;
    assign rise     = released & ~rel_q;
    assign done_evt = done_s ^ done_q;
    assign byte_evt = byte_s ^ byte_q;
    assign ctrl_wr  = cfg_wr && (cfg_addr == SBM_OFS_CTRL);
    assign launch_ld = load_pend & ~busy & bus_present_flag;
    assign launch_sw = (req_rd | req_wr) & ~busy & ~load_pend
                     & ~load_busy & bus_present_flag & released;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rel_q  <= 1'b0;
            done_q <= 1'b0;
            byte_q <= 1'b0;
        end else begin
            rel_q  <= released;
            done_q <= done_s;
            byte_q <= byte_s;
        end
    end

    // Pullup strap caught when the later reset releases
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_ok         <= 1'b0;
            bus_present_flag <= 1'b0;
        end else if (rise) begin
            strap_ok         <= scl_s;
            bus_present_flag <= scl_s;
        end else if (ctrl_wr) begin
            // Re-enable only possible when a pullup was seen
            bus_present_flag <= cfg_wdata[SBM_BIT_PRESENT]
                              & strap_ok;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_address_skip_select <= 1'b0;
            word_reg                 <= SBM_RST_BYTE;
        end else begin
            if (ctrl_wr)
                word_address_skip_select <= cfg_wdata[SBM_BIT_SKIP];
            if (cfg_wr && (cfg_addr == SBM_OFS_WORD))
                word_reg <= cfg_wdata;
        end
    end

    // Set by the engine wins over a software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            bus_error_flag <= 1'b0;
        else if (done_evt && e_err)
            bus_error_flag <= 1'b1;
        else if (ctrl_wr && cfg_wdata[SBM_BIT_ERR])
            bus_error_flag <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req_rd <= 1'b0;
            req_wr <= 1'b0;
        end else if (!bus_present_flag) begin
            req_rd <= 1'b0;
            req_wr <= 1'b0;
        end else if (launch_sw) begin
            // Read first when both were asked together
            req_rd <= 1'b0;
            req_wr <= req_wr & req_rd;
        end else if (ctrl_wr) begin
            req_rd <= req_rd | cfg_wdata[SBM_BIT_RD_REQ];
            req_wr <= req_wr | cfg_wdata[SBM_BIT_WR_REQ];
        end
    end

    // Command launch; fields stay still until the engine reports done
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_pend <= 1'b0;
            busy      <= 1'b0;
            load_busy <= 1'b0;
            cmd_tgl   <= 1'b0;
            c_op      <= OP_WRITE;
            c_word    <= SBM_RST_BYTE;
            c_wdata   <= SBM_RST_BYTE;
            c_count   <= 7'h01;
            c_skip    <= 1'b0;
        end else begin
            if (rise)
                load_pend <= scl_s;
            else if (launch_ld || !bus_present_flag)
                load_pend <= 1'b0;
            if (launch_ld) begin
                cmd_tgl   <= ~cmd_tgl;
                busy      <= 1'b1;
                load_busy <= 1'b1;
                c_op      <= OP_MREAD;
                c_word    <= SBM_LOAD_START;
                c_count   <= SBM_LOAD_BYTES;
                c_skip    <= word_address_skip_select;
            end else if (launch_sw) begin
                cmd_tgl   <= ~cmd_tgl;
                busy      <= 1'b1;
                c_op      <= req_rd ? OP_READ : OP_WRITE;
                c_word    <= word_reg;
                c_wdata   <= data_reg;
                c_count   <= 7'h01;
                c_skip    <= word_address_skip_select;
            end else if (done_evt) begin
                busy      <= 1'b0;
                load_busy <= 1'b0;
            end
        end
    end

    // Returned bytes go to the data register or out as load records
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_reg    <= SBM_RST_BYTE;
            load_valid  <= 1'b0;
            load_port   <= 2'h0;
            load_offset <= 7'h00;
            load_data   <= SBM_RST_BYTE;
            load_cnt    <= 7'h00;
        end else begin
            load_valid <= 1'b0;
            if (launch_ld)
                load_cnt <= 7'h00;
            if (byte_evt && load_busy) begin
                load_valid  <= 1'b1;
                load_data   <= rdata;
                load_offset <= load_cnt;
                load_port   <= port_of(load_cnt);
                load_cnt    <= load_cnt + 7'h01;
            end else if (byte_evt) begin
                data_reg <= rdata;
            end else if (cfg_wr && (cfg_addr == SBM_OFS_DATA)) begin
                data_reg <= cfg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            cfg_rdata <= SBM_RST_BYTE;
        else if (cfg_rd) begin
            case (cfg_addr)
                SBM_OFS_DATA: cfg_rdata <= data_reg;
                SBM_OFS_WORD: cfg_rdata <= word_reg;
                SBM_OFS_CTRL: cfg_rdata <= {word_address_skip_select, 1'b0,
                                            load_busy, busy,
                                            bus_present_flag, bus_error_flag,
                                            req_wr, req_rd};
                default:      cfg_rdata <= SBM_RST_BYTE;
            endcase
        end
    end

    // Serial engine on the link clock
    assign e_read  = (e_op != OP_WRITE);
    assign tif.run = (e_state != E_IDLE);

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cmd_q     <= 1'b0;
            e_state   <= E_IDLE;
            step      <= STEP_DEV_W;
            e_op      <= OP_WRITE;
            e_word    <= SBM_RST_BYTE;
            e_wdata   <= SBM_RST_BYTE;
            e_left    <= 7'h00;
            e_skip    <= 1'b0;
            e_restart <= 1'b0;
            e_err     <= 1'b0;
            ack_smp   <= 1'b0;
            shreg     <= SBM_RST_BYTE;
            bit_cnt   <= 4'h0;
            rdata     <= SBM_RST_BYTE;
            byte_tgl  <= 1'b0;
            done_tgl  <= 1'b0;
        end else begin
            cmd_q <= cmd_s;
            case (e_state)
                E_IDLE: if (cmd_s ^ cmd_q) begin
                    e_op      <= c_op;
                    e_word    <= c_word;
                    e_wdata   <= c_wdata;
                    e_left    <= c_count;
                    e_skip    <= c_skip;
                    e_restart <= 1'b0;
                    e_err     <= 1'b0;
                    e_state   <= E_START;
                end
                E_START: if (tif.tick && tif.phase == 2'h3) begin
                    bit_cnt <= 4'h0;
                    e_state <= E_TX;
                    if (e_read && (e_skip || e_restart)) begin
                        shreg <= SBM_DEV_RD;
                        step  <= STEP_DEV_R;
                    end else begin
                        shreg <= SBM_DEV_WR;
                        step  <= STEP_DEV_W;
                    end
                end
                E_TX: if (tif.tick) begin
                    if (tif.phase == 2'h2 && bit_cnt == SBM_ACK_BIT)
                        ack_smp <= sda_s;
                    if (tif.phase == 2'h3) begin
                        if (bit_cnt != SBM_ACK_BIT) begin
                            shreg   <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (ack_smp) begin
                            e_err   <= 1'b1;
                            e_state <= E_STOP;
                        end else begin
                            bit_cnt <= 4'h0;
                            case (step)
                                STEP_DEV_W: if (e_skip) begin
                                    step  <= STEP_DATA;
                                    shreg <= e_wdata;
                                end else begin
                                    step  <= STEP_WORD;
                                    shreg <= e_word;
                                end
                                STEP_WORD: if (e_read) begin
                                    e_restart <= 1'b1;
                                    e_state   <= E_START;
                                end else begin
                                    step  <= STEP_DATA;
                                    shreg <= e_wdata;
                                end
                                STEP_DATA:  e_state <= E_STOP;
                                default:    e_state <= E_RX;
                            endcase
                        end
                    end
                end
                E_RX: if (tif.tick) begin
                    if (tif.phase == 2'h2 && bit_cnt != SBM_ACK_BIT)
                        shreg <= {shreg[6:0], sda_s};
                    if (tif.phase == 2'h3) begin
                        if (bit_cnt == 4'h7) begin
                            rdata    <= shreg;
                            byte_tgl <= ~byte_tgl;
                        end
                        if (bit_cnt != SBM_ACK_BIT) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (e_left > 7'h01) begin
                            e_left  <= e_left - 7'h01;
                            bit_cnt <= 4'h0;
                        end else begin
                            e_state <= E_STOP;
                        end
                    end
                end
                E_STOP: if (tif.tick && tif.phase == 2'h3) begin
                    e_state  <= E_IDLE;
                    done_tgl <= ~done_tgl;
                end
                default: e_state <= E_IDLE;
            endcase
        end
    end

    // SCL low in phases 0-1; SDA moves only in phase 1 or 3 as framed
    always_comb begin
        next_scl = 1'b0;
        next_sda = sda_oe;
        case (e_state)
            E_IDLE: next_sda = 1'b0;
            E_START: begin
                next_scl = (tif.phase < 2'h2);
                if (tif.phase == 2'h1)
                    next_sda = 1'b0;
                if (tif.phase == 2'h3)
                    next_sda = 1'b1;
            end
            E_TX: begin
                next_scl = (tif.phase < 2'h2);
                if (tif.phase == 2'h1)
                    next_sda = (bit_cnt != SBM_ACK_BIT) & ~shreg[7];
            end
            E_RX: begin
                next_scl = (tif.phase < 2'h2);
                if (tif.phase == 2'h1)
                    next_sda = (bit_cnt == SBM_ACK_BIT)
                             && (e_left > 7'h01);
            end
            E_STOP: begin
                next_scl = (tif.phase < 2'h2);
                if (tif.phase == 2'h1)
                    next_sda = 1'b1;
                if (tif.phase == 2'h3)
                    next_sda = 1'b0;
            end
            default: next_sda = 1'b0;
        endcase
    end

    // Open-drain: only ever pull low, pullups make the high level
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_oe <= next_scl;
            sda_oe <= next_sda;
        end
    end
endmodule

// ### sbm_top_bench.sv
// Self-checking bench for the serial EEPROM bus master
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module sbm_top_bench;
    import sbm_pkg::*;
    logic       ref_clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst = 1'b1;
    logic       pcie_reset_n = 1'b0;
    logic       global_reset_n = 1'b1;
    logic [7:0] cfg_addr = 8'h00;
    logic       cfg_wr = 1'b0;
    logic       cfg_rd = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata, load_data, rd_v;
    logic [6:0] load_offset;
    logic [1:0] load_port;
    logic       scl_o, scl_oe, sda_o, sda_oe, load_valid, sda_pull;
    logic       strap_low = 1'b0;
    logic       nack_addr = 1'b1;
    logic       scl_i, sda_i;
    int         fail_count = 0;
    int         n_tests = 0;
    int         n0;
    // Pull-ups win unless a party pulls the line down
    assign scl_i = !scl_oe && !strap_low;
    assign sda_i = !sda_oe && !sda_pull;
    always #50 ref_clk = ~ref_clk;
    initial begin
        #2.3;
        forever #7.5 link_clk = ~link_clk;
    end
    sbm_top uut (.ref_clk, .link_clk, .rst, .pcie_reset_n, .global_reset_n,
        .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .scl_i, .scl_o,
        .scl_oe, .sda_i, .sda_o, .sda_oe, .load_valid, .load_port,
        .load_offset, .load_data);
    sbm_eeprom_model eeprom (.scl(scl_i), .sda(sda_i), .nack_addr, .sda_pull);
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    // Strobe low for a cycle so back-to-back calls never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a);
        cfg_addr = a;
        cfg_rd = 1'b1;
        cyc(1);
        cfg_rd = 1'b0;
        cyc(1);
        rd_v = cfg_rdata;
    endtask
    task automatic wait_idle;
        rd(SBM_OFS_CTRL);
        for (int i = 0; i < 400 && rd_v[5:4] !== 2'h0; i++) begin
            cyc(50);
            rd(SBM_OFS_CTRL);
        end
        `CHK("idle", 2'h0, rd_v[5:4])
    endtask
    // One-cycle record pulse is polled every cycle, past the launch edge
    task automatic wait_load(input logic [6:0] o, input logic [7:0] d);
        for (int i = 0; i < 9000 && load_valid !== 1'b1; i++)
            cyc(1);
        `CHK("load valid", 1'b1, load_valid)
        `CHK("load offset", o, load_offset)
        `CHK("load port", 2'h0, load_port)
        `CHK("load data", d, load_data)
        cyc(1);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        pcie_reset_n = 1'b0;
        cyc(3);
        rst = 1'b0;
        cyc(2);
        pcie_reset_n = 1'b1;
        cyc(10);
    endtask
    task automatic t_load_nack;
        wait_idle();
        `CHK("ctrl after load", 8'h0c, rd_v)
        `CHK("load starts", 1, eeprom.starts)
        wr(SBM_OFS_CTRL, 8'h0c);
        rd(SBM_OFS_CTRL);
        `CHK("error cleared", 8'h08, rd_v)
        nack_addr = 1'b0;
        $display("load nack test done");
    endtask
    task automatic t_write;
        wr(SBM_OFS_WORD, 8'h3c);
        wr(SBM_OFS_DATA, 8'h5a);
        wr(SBM_OFS_CTRL, 8'h0a);
        wait_idle();
        `CHK("ctrl after write", 8'h08, rd_v)
        `CHK("stored byte", 8'h5a, eeprom.mem[8'h3c])
        $display("write test done");
    endtask
    task automatic t_read;
        eeprom.mem[8'h21] = 8'ha7;
        wr(SBM_OFS_WORD, 8'h21);
        wr(SBM_OFS_CTRL, 8'h09);
        wait_idle();
        rd(SBM_OFS_DATA);
        `CHK("read byte", 8'ha7, rd_v)
        $display("read test done");
    endtask
    // Slave pointer sits on 22h after the previous read
    task automatic t_skip;
        eeprom.mem[8'h22] = 8'hc3;
        wr(SBM_OFS_CTRL, 8'h89);
        wait_idle();
        `CHK("ctrl after skip", 8'h88, rd_v)
        rd(SBM_OFS_DATA);
        `CHK("skip byte", 8'hc3, rd_v)
        wr(SBM_OFS_CTRL, 8'h08);
        $display("skip test done");
    endtask
    task automatic t_disable;
        n0 = eeprom.starts;
        wr(SBM_OFS_CTRL, 8'h00);
        wr(SBM_OFS_CTRL, 8'h01);
        cyc(2000);
        rd(SBM_OFS_CTRL);
        `CHK("ctrl disabled", 8'h00, rd_v)
        `CHK("starts disabled", n0, eeprom.starts)
        $display("disable test done");
    endtask
    // Detection waits for the later reset; load left running, cut by the strap test's reset
    task automatic t_load;
        n0 = eeprom.starts;
        eeprom.mem[8'h00] = 8'h96;
        eeprom.mem[8'h01] = 8'h3c;
        eeprom.mem[8'h02] = 8'h00;
        global_reset_n = 1'b0;
        do_reset();
        rd(SBM_OFS_CTRL);
        `CHK("ctrl before global_reset_n", 8'h00, rd_v)
        global_reset_n = 1'b1;
        cyc(10);
        wr(SBM_OFS_CTRL, 8'h09);
        rd(SBM_OFS_CTRL);
        `CHK("ctrl during load", 8'h39, rd_v)
        wait_load(7'h00, 8'h96);
        `CHK("load restart", n0 + 2, eeprom.starts)
        wait_load(7'h01, 8'h3c);
        $display("load test done");
    endtask
    task automatic t_strap;
        n0 = eeprom.starts;
        strap_low = 1'b1;
        do_reset();
        wr(SBM_OFS_CTRL, 8'h09);
        cyc(2000);
        rd(SBM_OFS_CTRL);
        `CHK("ctrl strapped", 8'h00, rd_v)
        `CHK("starts strapped", n0, eeprom.starts)
        $display("strap test done");
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        do_reset();
        t_load_nack();
        t_write();
        t_read();
        t_skip();
        t_disable();
        t_load();
        t_strap();
        final_report();
    end
    initial begin
        #8000000;
        fail_count++;
        final_report();
    end
endmodule

// ### sbm_top_chk.sv
// Pin-level assertions for the serial EEPROM bus master
`timescale 1ns/100ps
module sbm_top_chk
    import sbm_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       link_clk,
    input wire logic       rst,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       load_valid,
    input wire logic [1:0] load_port,
    input wire logic [6:0] load_offset
);
    localparam int LOW_CYC = 2 * SBM_QTR_CYC;
    logic [9:0] lo_cnt;
    logic [1:0] exp_port;
    assign exp_port = load_offset < 7'h28 ? 2'h0 : load_offset < 7'h36 ? 2'h1
                    : load_offset < 7'h44 ? 2'h2 : 2'h3;
    // Length of each SCL low phase in link clocks
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) lo_cnt <= '0;
        else lo_cnt <= scl_oe ? lo_cnt + 10'h1 : '0;
    end
    AST_OPEN_DRAIN: assert property (
        @(posedge link_clk) disable iff (rst)
        scl_o == 1'b0 && sda_o == 1'b0) else $error("pin driven high");
    AST_START_SHAPE: assert property (
        @(posedge link_clk) disable iff (rst) $rose(sda_oe) && !scl_oe
        |-> !scl_oe [*8] ##[1:600] scl_oe) else $error("bad start");
    AST_STOP_IDLE: assert property (
        @(posedge link_clk) disable iff (rst) $fell(sda_oe) && !scl_oe &&
        !$past(scl_oe) |-> !scl_oe [*8]) else $error("bad stop");
    AST_SCL_LOW_LEN: assert property (
        @(posedge link_clk) disable iff (rst)
        $fell(scl_oe) |-> lo_cnt == 10'(LOW_CYC)) else $error("scl low len");
    AST_SCL_RELEASE: assert property (
        @(posedge link_clk) disable iff (rst)
        $rose(scl_oe) |-> scl_oe [*8] ##[1:600] !scl_oe) else $error("scl");
    AST_LOAD_PULSE: assert property (
        @(posedge ref_clk) disable iff (rst)
        load_valid |=> !load_valid) else $error("load pulse too long");
    AST_LOAD_PORT: assert property (
        @(posedge ref_clk) disable iff (rst)
        load_valid |-> load_port == exp_port) else $error("load port");
    AST_LOAD_RANGE: assert property (
        @(posedge ref_clk) disable iff (rst)
        load_valid |-> load_offset <= 7'h51) else $error("load offset");
    COV_START: cover property (@(posedge link_clk) $rose(sda_oe) && !scl_oe);
    COV_STOP: cover property (@(posedge link_clk) $fell(sda_oe) && !scl_oe);
    COV_LOAD: cover property (@(posedge ref_clk) load_valid);
endmodule
bind sbm_top sbm_top_chk chk (.ref_clk, .link_clk, .rst, .scl_o, .scl_oe,
    .sda_o, .sda_oe, .load_valid, .load_port, .load_offset);
